//--- dv/dtc_core_model.sv
// Core model that vectors to pending timer and pin interrupts
`timescale 1ns/100ps
`default_nettype none
module dtc_core_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] req,
  input wire logic [3:0] ack_en,
  input wire logic [3:0] dly,
  output logic [3:0] ack
);
  logic [3:0] wait_r; // Cycles spent before vectoring
  // Vector to enabled pending requests after dly cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_r <= 4'h0;
      ack <= 4'h0;
    end else if (|(req & ack_en) && ack == 4'h0) begin
      if (wait_r >= dly) begin
        // One-cycle acknowledge clears the flag
        ack <= req & ack_en;
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      // Idle, or ack just given
      ack <= 4'h0;
      wait_r <= 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- dv/test_dtc_top.sv
// Self-checking bench of the dual timer/counter block
`timescale 1ns/100ps
`default_nettype none
module test_dtc_top;
  logic clk = 1'b0; // Core clock
  logic reset = 1'b1; // Sync reset
  logic [3:0] addr = 4'h0; // Register address
  logic [7:0] wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic rd_d = 1'b0; // Read taken at last edge
  logic [1:0] evp = 2'b00; // Event pins {t1,t0}
  logic x0n = 1'b1; // Ext interrupt 0 pin
  logic x1n = 1'b1; // Ext interrupt 1 pin
  logic [3:0] ack_en = 4'h0; // Core vectoring enables
  logic [3:0] dly = 4'h1; // Core vectoring delay
  logic [3:0] ack; // Acks {x1,x0,t1,t0}
  logic [7:0] rdata; // Read data
  logic [3:0] reqv; // Requests {x1,x0,t1,t0}
  logic irq; // Interrupt output
  logic [7:0] exq[$]; // Expected read data
  logic [7:0] rv; // Random byte
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  // Clock, 20 ns period
  always #10 clk = ~clk;

  dtc_top dut (
    .clk(clk), .reset(reset), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .t0_event_pin(evp[0]), .t1_event_pin(evp[1]),
    .ext_irq0_pin_n(x0n), .ext_irq1_pin_n(x1n),
    .ack_t0(ack[0]), .ack_t1(ack[1]), .ack_x0(ack[2]), .ack_x1(ack[3]),
    .req_t0(reqv[0]), .req_t1(reqv[1]), .req_x0(reqv[2]), .req_x1(reqv[3]),
    .irq(irq)
  );

  dtc_core_model core (
    .clk(clk), .reset(reset), .req(reqv), .ack_en(ack_en), .dly(dly), .ack(ack)
  );

  // Verdict and end of run
  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compare one byte and count it
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  // Compare irq and requests where settled
  task automatic pins_are(input logic [4:0] e);
    @(negedge clk);
    chk("irq_req", {3'h0, e}, {3'h0, irq, reqv});
    @(posedge clk);
  endtask

  // One-cycle write strobe, then a gap
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // One-cycle read strobe; expected data noted
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    exq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // Event pulse; the falling edge is one event
  task automatic pulse(input int t);
    evp[t] <= 1'b1;
    @(posedge clk);
    evp[t] <= 1'b0;
    @(posedge clk);
    @(posedge clk);
  endtask

  // Bounded wait for one request line
  task automatic wait_req(input int i);
    for (int k = 0; k < 100; k++) begin
      @(negedge clk);
      if (reqv[i] === 1'b1) break;
    end
    chk("req_wait", 8'h01, {7'h00, reqv[i]});
    @(posedge clk);
  endtask

  // Read data stand in the cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      chk("reg_rdata", exq.pop_front(), rdata);
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(37993));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Reset values, unmapped place at 9
    for (int a = 0; a < 10; a++) begin
      rd_reg(4'(a), 8'h00);
    end
    // Count bytes and mode register read back
    for (int a = 1; a < 6; a++) begin
      rv = 8'($urandom());
      wr_reg(4'(a), rv);
      rd_reg(4'(a), rv);
    end
    wr_reg(4'h6, 8'hFF);
    rd_reg(4'h6, 8'h00);
    rd_reg(4'h7, 8'h00);
    // Timer 1 reload mode, ticks
    wr_reg(4'h1, 8'h20);
    wr_reg(4'h3, 8'hFE);
    wr_reg(4'h5, 8'hA0);
    wr_reg(4'h8, 8'h02);
    wr_reg(4'h0, 8'h40);
    wait_req(1);
    wr_reg(4'h0, 8'h80);
    rd_reg(4'h3, 8'hA0);
    rd_reg(4'h0, 8'h80);
    rd_reg(4'h6, 8'h02);
    pins_are(5'h12);
    // Core vectors, flag cleared
    ack_en <= 4'h2;
    repeat (8) @(posedge clk);
    ack_en <= 4'h0;
    rd_reg(4'h0, 8'h00);
    pins_are(5'h10);
    wr_reg(4'h8, 8'h00);
    pins_are(5'h00);
    wr_reg(4'h8, 8'h02);
    pins_are(5'h10);
    wr_reg(4'h7, 8'h02);
    pins_are(5'h00);
    rd_reg(4'h6, 8'h00);
    // Timer 0 as 16-bit event counter
    wr_reg(4'h1, 8'h05);
    wr_reg(4'h2, 8'hFF);
    wr_reg(4'h4, 8'h12);
    wr_reg(4'h0, 8'h10);
    pulse(0);
    wr_reg(4'h0, 8'h00);
    pulse(0);
    rd_reg(4'h2, 8'h00);
    rd_reg(4'h4, 8'h13);
    // Gated: pin low blocks, pin high lets it count
    wr_reg(4'h1, 8'h0D);
    wr_reg(4'h0, 8'h10);
    x0n <= 1'b0;
    pulse(0);
    x0n <= 1'b1;
    pulse(0);
    rd_reg(4'h2, 8'h01);
    rd_reg(4'h0, 8'h12);
    // Timer 1 prescaled across the divide-by-32 carry
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'h40);
    wr_reg(4'h3, 8'hFF);
    wr_reg(4'h5, 8'hFF);
    wr_reg(4'h0, 8'h40);
    pulse(1);
    rd_reg(4'h3, 8'hE0);
    rd_reg(4'h5, 8'h00);
    rd_reg(4'h0, 8'hC0);
    wr_reg(4'h1, 8'h70);
    pulse(1);
    rd_reg(4'h3, 8'hE0);
    // Timer 0 split mode, low byte counts events
    wr_reg(4'h1, 8'h07);
    wr_reg(4'h2, 8'hFF);
    wr_reg(4'h0, 8'h10);
    pulse(0);
    rd_reg(4'h2, 8'h00);
    rd_reg(4'h0, 8'h30);
    // Timer 0 reload and timer 1 16-bit, both on events
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'h56);
    wr_reg(4'h2, 8'hFF);
    wr_reg(4'h4, 8'h5A);
    wr_reg(4'h3, 8'hFF);
    wr_reg(4'h5, 8'hFF);
    wr_reg(4'h0, 8'h50);
    pulse(0);
    pulse(1);
    rd_reg(4'h2, 8'h5A);
    rd_reg(4'h4, 8'h5A);
    rd_reg(4'h3, 8'h00);
    rd_reg(4'h5, 8'h00);
    rd_reg(4'h0, 8'hF0);
    // Core vectors to timer 0 only
    ack_en <= 4'h1;
    repeat (8) @(posedge clk);
    ack_en <= 4'h0;
    rd_reg(4'h0, 8'hD0);
    // Edge kinds on both pins
    wr_reg(4'h0, 8'h05);
    wr_reg(4'h7, 8'h0F);
    wr_reg(4'h8, 8'h00);
    x1n <= 1'b0;
    repeat (3) @(posedge clk);
    pins_are(5'h08);
    dly <= 4'h4;
    ack_en <= 4'h8;
    repeat (10) @(posedge clk);
    ack_en <= 4'h0;
    pins_are(5'h00);
    x1n <= 1'b1;
    repeat (3) @(posedge clk);
    pins_are(5'h08);
    x0n <= 1'b0;
    repeat (3) @(posedge clk);
    pins_are(5'h0C);
    wr_reg(4'h0, 8'h05);
    x0n <= 1'b1;
    repeat (3) @(posedge clk);
    pins_are(5'h00);
    // Level kinds, then vectoring of int 0
    wr_reg(4'h0, 8'h00);
    x0n <= 1'b0;
    x1n <= 1'b0;
    repeat (3) @(posedge clk);
    pins_are(5'h0C);
    x0n <= 1'b1;
    x1n <= 1'b1;
    ack_en <= 4'h4;
    repeat (10) @(posedge clk);
    pins_are(5'h08);
    rd_reg(4'h6, 8'h0C);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- verilog/dtc_pkg.sv
// Constants, types and register map of the dual timer/counter block
`default_nettype none
package dtc_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_TCTRL = 4'h0; // timer_control_flags
  localparam logic [3:0] ADDR_TMODE = 4'h1; // timer_mode_select
  localparam logic [3:0] ADDR_T0_LO = 4'h2; // timer0_count_low
  localparam logic [3:0] ADDR_T1_LO = 4'h3; // timer1_count_low
  localparam logic [3:0] ADDR_T0_HI = 4'h4; // timer0_count_high
  localparam logic [3:0] ADDR_T1_HI = 4'h5; // timer1_count_high
  localparam logic [3:0] ADDR_ISTAT = 4'h6; // Sticky event status, read only
  localparam logic [3:0] ADDR_ICLR = 4'h7; // Status clear, write only
  localparam logic [3:0] ADDR_IEN = 4'h8; // Interrupt enable

  // Bit positions in timer_control_flags
  localparam int TC_T1_OVF = 7; // t1_overflow_flag
  localparam int TC_T1_RUN = 6; // t1_run_bit
  localparam int TC_T0_OVF = 5; // t0_overflow_flag
  localparam int TC_T0_RUN = 4; // t0_run_bit
  localparam int TC_X1_FLG = 3; // ext_irq1_edge_flag
  localparam int TC_X1_TYP = 2; // ext_irq1_type_bit
  localparam int TC_X0_FLG = 1; // ext_irq0_edge_flag
  localparam int TC_X0_TYP = 0; // ext_irq0_type_bit

  // Bit positions in timer_mode_select
  localparam int TM_T1_GATE = 7; // Gating control, timer 1
  localparam int TM_T1_CNT = 6; // Counter/timer select, timer 1
  localparam int TM_T1_MODE = 4; // operating_mode_field low bit, timer 1
  localparam int TM_T0_GATE = 3; // Gating control, timer 0
  localparam int TM_T0_CNT = 2; // Counter/timer select, timer 0
  localparam int TM_T0_MODE = 0; // operating_mode_field low bit, timer 0

  // Event bits in status, clear and enable registers
  localparam int EV_T0 = 0;
  localparam int EV_T1 = 1;
  localparam int EV_X0 = 2;
  localparam int EV_X1 = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Prescaler width for the divide-by-32 mode
  localparam int PRESC_W = 5;
  // Clock cycles per internal timer interval
  localparam logic [3:0] TICK_CYCLES = 4'hC;
  localparam logic [3:0] TICK_LAST = TICK_CYCLES - 4'h1;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_PRESC8 = 2'b00,
    MODE_CNT16 = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } dtc_mode_e;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] tctrl;
    logic [7:0] tmode;
    logic [7:0] t0_lo;
    logic [7:0] t0_hi;
    logic [7:0] t1_lo;
    logic [7:0] t1_hi;
    logic [3:0] tick;
    logic t0_pin_d;
    logic t1_pin_d;
    logic x0_pin_d;
    logic x1_pin_d;
    logic [3:0] istat;
    logic [3:0] ien;
    logic [7:0] rdata;
    logic [3:0] req;
    logic irq;
  } dtc_state_s;

endpackage
`default_nettype wire

//--- verilog/dtc_top.sv
// Dual timer/counter with two external interrupt inputs
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module dtc_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic t0_event_pin,
  input wire logic t1_event_pin,
  input wire logic ext_irq0_pin_n,
  input wire logic ext_irq1_pin_n,
  input wire logic ack_t0,
  input wire logic ack_t1,
  input wire logic ack_x0,
  input wire logic ack_x1,
  output logic req_t0,
  output logic req_t1,
  output logic req_x0,
  output logic req_x1,
  output logic irq
);

  localparam int PW = dtc_pkg::PRESC_W; // Prescaler width of mode 00

  // 8-bit increment with carry out
  function automatic logic [8:0] inc8(input logic [7:0] v, input logic en);
    return {1'b0, v} + {8'h00, en};
  endfunction

  // One counting step of a timer in modes 00 to 11: {overflow, high, low}
  function automatic logic [16:0] tmr_step(input logic [1:0] md, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic en);
    // Working sums of prescaler, low byte and high byte
    logic [PW:0] p;
    logic [8:0] l;
    logic [8:0] h;
    logic [16:0] r;
    p = {1'b0, lo[PW-1:0]} + {{PW{1'b0}}, en};
    l = inc8(lo, en);
    h = 9'h000;
    r = {1'b0, hi, lo};
    unique case (md)
      // Low five bits prescale, high byte counts
      dtc_pkg::MODE_PRESC8: begin
        h = inc8(hi, p[PW]);
        r = {h[8], h[7:0], lo[7:PW], p[PW-1:0]};
      end
      // Full 16-bit count
      dtc_pkg::MODE_CNT16: begin
        h = inc8(hi, l[8]);
        r = {h[8], h[7:0], l[7:0]};
      end
      // Low byte reloads from high byte on overflow
      dtc_pkg::MODE_RELOAD8: begin
        r = {l[8], hi, (l[8] ? hi : l[7:0])};
      end
      // Stopped: count held
      dtc_pkg::MODE_SPLIT: begin
        r = {1'b0, hi, lo};
      end
    endcase
    return r;
  endfunction

  dtc_pkg::dtc_state_s s_r; // Registered state
  dtc_pkg::dtc_state_s s_nxt; // Next state
  logic tick; // Internal interval pulse
  logic en0; // Timer 0 (or split low byte) count enable
  logic en1; // Timer 1 count enable
  logic en0h; // Split high byte count enable
  logic [1:0] md0; // Timer 0 mode
  logic [1:0] md1; // Timer 1 mode
  logic [16:0] st0; // Timer 0 step result
  logic [16:0] st1; // Timer 1 step result
  logic [8:0] sp_lo; // Split low byte increment
  logic [8:0] sp_hi; // Split high byte increment
  logic ovf0; // Event: timer 0 flag source
  logic ovf1; // Event: timer 1 flag source
  logic xs0; // Event: ext interrupt 0 trigger
  logic xs1; // Event: ext interrupt 1 trigger
  logic wr_tc; // Write strobes per register
  logic wr_t0l;
  logic wr_t0h;
  logic wr_t1l;
  logic wr_t1h;

  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    md0 = s_r.tmode[dtc_pkg::TM_T0_MODE +: 2];
    md1 = s_r.tmode[dtc_pkg::TM_T1_MODE +: 2];
    wr_tc = reg_wr && (reg_addr == dtc_pkg::ADDR_TCTRL);
    wr_t0l = reg_wr && (reg_addr == dtc_pkg::ADDR_T0_LO);
    wr_t0h = reg_wr && (reg_addr == dtc_pkg::ADDR_T0_HI);
    wr_t1l = reg_wr && (reg_addr == dtc_pkg::ADDR_T1_LO);
    wr_t1h = reg_wr && (reg_addr == dtc_pkg::ADDR_T1_HI);

    // Interval divider
    tick = (s_r.tick == dtc_pkg::TICK_LAST);
    s_nxt.tick = tick ? 4'h0 : s_r.tick + 4'h1;

    // Pin history for edge detection
    s_nxt.t0_pin_d = t0_event_pin;
    s_nxt.t1_pin_d = t1_event_pin;
    s_nxt.x0_pin_d = ext_irq0_pin_n;
    s_nxt.x1_pin_d = ext_irq1_pin_n;

    // Count enables: run bit, optional gate, interval or falling event edge
    en0 = s_r.tctrl[dtc_pkg::TC_T0_RUN]
      && (!s_r.tmode[dtc_pkg::TM_T0_GATE] || ext_irq0_pin_n)
      && (s_r.tmode[dtc_pkg::TM_T0_CNT] ? (s_r.t0_pin_d && !t0_event_pin) : tick);
    en1 = s_r.tctrl[dtc_pkg::TC_T1_RUN]
      && (!s_r.tmode[dtc_pkg::TM_T1_GATE] || ext_irq1_pin_n)
      && (s_r.tmode[dtc_pkg::TM_T1_CNT] ? (s_r.t1_pin_d && !t1_event_pin) : tick);
    // Split high byte is an interval counter run by timer 1's run bit
    en0h = s_r.tctrl[dtc_pkg::TC_T1_RUN] && tick;

    st0 = tmr_step(md0, s_r.t0_lo, s_r.t0_hi, en0);
    st1 = tmr_step(md1, s_r.t1_lo, s_r.t1_hi, en1);
    // Split mode: low byte on timer 0 controls, high byte on timer 1's run bit
    sp_lo = inc8(s_r.t0_lo, en0);
    sp_hi = inc8(s_r.t0_hi, en0h);

    // Counter bytes: split mode or common step; software write wins
    if (md0 == dtc_pkg::MODE_SPLIT) begin
      s_nxt.t0_lo = sp_lo[7:0];
      s_nxt.t0_hi = sp_hi[7:0];
      ovf0 = sp_lo[8];
      ovf1 = sp_hi[8];
    end else begin
      s_nxt.t0_lo = st0[7:0];
      s_nxt.t0_hi = st0[15:8];
      ovf0 = st0[16];
      ovf1 = st1[16];
    end
    // Timer 1 steps in every timer 0 mode; split only takes its flag
    s_nxt.t1_lo = st1[7:0];
    s_nxt.t1_hi = st1[15:8];
    // Software byte writes override the counting step
    if (wr_t0l) begin
      s_nxt.t0_lo = reg_wdata;
    end
    if (wr_t0h) begin
      s_nxt.t0_hi = reg_wdata;
    end
    if (wr_t1l) begin
      s_nxt.t1_lo = reg_wdata;
    end
    if (wr_t1h) begin
      s_nxt.t1_hi = reg_wdata;
    end

    // External interrupt triggers: edge or low level per type bit
    // Int 1 sees both edges; int 0 only the falling one
    if (s_r.tctrl[dtc_pkg::TC_X1_TYP]) begin
      xs1 = (s_r.x1_pin_d != ext_irq1_pin_n);
    end else begin
      xs1 = !ext_irq1_pin_n;
    end
    if (s_r.tctrl[dtc_pkg::TC_X0_TYP]) begin
      xs0 = s_r.x0_pin_d && !ext_irq0_pin_n;
    end else begin
      xs0 = !ext_irq0_pin_n;
    end

    // Mode register write
    if (reg_wr && (reg_addr == dtc_pkg::ADDR_TMODE)) begin
      s_nxt.tmode = reg_wdata;
    end

    // Control flags: software write, then vector clears, then hardware sets win
    if (wr_tc) begin
      s_nxt.tctrl = reg_wdata;
    end
    if (ack_t0) begin
      s_nxt.tctrl[dtc_pkg::TC_T0_OVF] = 1'b0;
    end
    if (ack_t1) begin
      s_nxt.tctrl[dtc_pkg::TC_T1_OVF] = 1'b0;
    end
    if (ack_x0) begin
      s_nxt.tctrl[dtc_pkg::TC_X0_FLG] = 1'b0;
    end
    if (ack_x1) begin
      s_nxt.tctrl[dtc_pkg::TC_X1_FLG] = 1'b0;
    end
    if (ovf0) begin
      s_nxt.tctrl[dtc_pkg::TC_T0_OVF] = 1'b1;
    end
    if (ovf1) begin
      s_nxt.tctrl[dtc_pkg::TC_T1_OVF] = 1'b1;
    end
    if (xs0) begin
      s_nxt.tctrl[dtc_pkg::TC_X0_FLG] = 1'b1;
    end
    if (xs1) begin
      s_nxt.tctrl[dtc_pkg::TC_X1_FLG] = 1'b1;
    end

    // Interrupt request lines follow the flags
    s_nxt.req[dtc_pkg::EV_T0] = s_nxt.tctrl[dtc_pkg::TC_T0_OVF];
    s_nxt.req[dtc_pkg::EV_T1] = s_nxt.tctrl[dtc_pkg::TC_T1_OVF];
    s_nxt.req[dtc_pkg::EV_X0] = s_nxt.tctrl[dtc_pkg::TC_X0_FLG];
    s_nxt.req[dtc_pkg::EV_X1] = s_nxt.tctrl[dtc_pkg::TC_X1_FLG];

    // Sticky status: clear by write of ones, set wins
    if (reg_wr && (reg_addr == dtc_pkg::ADDR_ICLR)) begin
      s_nxt.istat = s_r.istat & ~reg_wdata[3:0];
    end
    s_nxt.istat = s_nxt.istat | {xs1, xs0, ovf1, ovf0};
    if (reg_wr && (reg_addr == dtc_pkg::ADDR_IEN)) begin
      s_nxt.ien = reg_wdata[3:0];
    end
    // Single level interrupt from enabled sticky status
    s_nxt.irq = |(s_nxt.istat & s_nxt.ien);

    // Read data one cycle after the strobe, zero otherwise
    s_nxt.rdata = dtc_pkg::RST_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        dtc_pkg::ADDR_TCTRL: s_nxt.rdata = s_r.tctrl;
        dtc_pkg::ADDR_TMODE: s_nxt.rdata = s_r.tmode;
        dtc_pkg::ADDR_T0_LO: s_nxt.rdata = s_r.t0_lo;
        dtc_pkg::ADDR_T1_LO: s_nxt.rdata = s_r.t1_lo;
        dtc_pkg::ADDR_T0_HI: s_nxt.rdata = s_r.t0_hi;
        dtc_pkg::ADDR_T1_HI: s_nxt.rdata = s_r.t1_hi;
        dtc_pkg::ADDR_ISTAT: s_nxt.rdata = {4'h0, s_r.istat};
        dtc_pkg::ADDR_IEN: s_nxt.rdata = {4'h0, s_r.ien};
        // Clear register and unmapped addresses read zero
        default: s_nxt.rdata = dtc_pkg::RST_BYTE;
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      // Interrupt pins idle high: no false edge after reset
      s_r.x0_pin_d <= 1'b1;
      s_r.x1_pin_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = s_r.rdata;
  assign req_t0 = s_r.req[dtc_pkg::EV_T0];
  assign req_t1 = s_r.req[dtc_pkg::EV_T1];
  assign req_x0 = s_r.req[dtc_pkg::EV_X0];
  assign req_x1 = s_r.req[dtc_pkg::EV_X1];
  assign irq = s_r.irq;

  // Checks on the block's own behaviour.
  // Most antecedents leave out cycles with a software write to the same
  // register: a byte write wins over counting, and a hardware set wins
  // over a write of the control flags, so such cycles prove nothing.
  // Requests mirror the flags from the same next state, and status is set
  // by the same events, so a request is checked in the same cycle as its flag.
  // Split mode moves timer 0's high byte under timer 1's run bit; the
  // gating checks allow for that.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_t1_ovf_set: assert property (
    (md1 == dtc_pkg::MODE_CNT16) && en1 && ({s_r.t1_hi, s_r.t1_lo} == 16'hFFFF)
    && (md0 != dtc_pkg::MODE_SPLIT) |=> s_r.tctrl[dtc_pkg::TC_T1_OVF])
    else $error("timer 1 overflow did not set its flag");

  a_t0_ack_clear: assert property (
    ack_t0 && !ovf0 && !wr_tc |=> !s_r.tctrl[dtc_pkg::TC_T0_OVF] && !req_t0)
    else $error("timer 0 flag not cleared by acknowledge");

  a_run_hold: assert property (
    !s_r.tctrl[dtc_pkg::TC_T1_RUN] && !wr_t1l && !wr_t1h |=> $stable(s_r.t1_lo))
    else $error("timer 1 counted while stopped");

  a_x1_both_edge: assert property (
    s_r.tctrl[dtc_pkg::TC_X1_TYP] && !wr_tc && $changed(ext_irq1_pin_n)
    |=> s_r.tctrl[dtc_pkg::TC_X1_FLG] && req_x1)
    else $error("edge on interrupt 1 did not raise its flag");

  a_x1_level: assert property (
    !s_r.tctrl[dtc_pkg::TC_X1_TYP] && !wr_tc && !ext_irq1_pin_n
    |=> s_r.tctrl[dtc_pkg::TC_X1_FLG])
    else $error("low level on interrupt 1 did not raise its flag");

  a_x0_no_rise: assert property (
    s_r.tctrl[dtc_pkg::TC_X0_TYP] && !s_r.tctrl[dtc_pkg::TC_X0_FLG] && !wr_tc
    && ext_irq0_pin_n |=> !s_r.tctrl[dtc_pkg::TC_X0_FLG])
    else $error("interrupt 0 flag set without a falling edge");

  a_x0_fall: assert property (
    s_r.tctrl[dtc_pkg::TC_X0_TYP] && $fell(ext_irq0_pin_n) && !wr_tc
    |=> s_r.tctrl[dtc_pkg::TC_X0_FLG])
    else $error("falling edge on interrupt 0 missed");

  a_byte_write: assert property (
    wr_t0h |=> (s_r.t0_hi == $past(reg_wdata)) ##1 1'b1)
    else $error("high byte write not stored");

  a_gate_block: assert property (
    s_r.tmode[dtc_pkg::TM_T0_GATE] && !ext_irq0_pin_n && !wr_t0l && !wr_t0h
    |=> $stable(s_r.t0_lo) && ($stable(s_r.t0_hi) || $past(md0 == dtc_pkg::MODE_SPLIT)))
    else $error("gated timer 0 counted with pin low");

  a_t1_reload: assert property (
    (md1 == dtc_pkg::MODE_RELOAD8) && en1 && (s_r.t1_lo == 8'hFF) && !wr_t1l
    |=> s_r.t1_lo == $past(s_r.t1_hi))
    else $error("auto reload did not copy the high byte");

  a_split_hi: assert property (
    (md0 == dtc_pkg::MODE_SPLIT) && en0h && !wr_t0h
    |=> s_r.t0_hi == $past(s_r.t0_hi) + 8'h01)
    else $error("split high byte did not count");

  a_req_follow: assert property (
    $rose(s_r.tctrl[dtc_pkg::TC_T1_OVF]) |-> req_t1 ##1 (req_t1 || $past(ack_t1) || $past(wr_tc)))
    else $error("overflow flag not presented as request");

  a_counter_mode: assert property (
    s_r.tmode[dtc_pkg::TM_T1_CNT] && !(s_r.t1_pin_d && !t1_event_pin) && !wr_t1l && !wr_t1h
    |=> $stable(s_r.t1_lo) && $stable(s_r.t1_hi))
    else $error("counter mode moved without an event");

  // Timer 0 reload, acknowledge, status and read data checks
  a_t0_reload: assert property (
    (md0 == dtc_pkg::MODE_RELOAD8) && en0 && (s_r.t0_lo == 8'hFF) && !wr_t0l
    |=> s_r.t0_lo == $past(s_r.t0_hi))
    else $error("timer 0 auto reload did not copy the high byte");

  a_x0_ack_clear: assert property (
    ack_x0 && !xs0 && !wr_tc
    |=> !s_r.tctrl[dtc_pkg::TC_X0_FLG] && !req_x0)
    else $error("interrupt 0 flag not cleared when serviced");

  a_x1_ack_clear: assert property (
    ack_x1 && !xs1 && !wr_tc
    |=> !s_r.tctrl[dtc_pkg::TC_X1_FLG] && !req_x1)
    else $error("interrupt 1 flag not cleared when serviced");

  a_ovf_status: assert property (
    ovf0 |=> s_r.istat[dtc_pkg::EV_T0] && req_t0 && s_r.tctrl[dtc_pkg::TC_T0_OVF])
    else $error("timer 0 overflow not latched as status and request");

  a_status_sticky: assert property (
    s_r.istat[dtc_pkg::EV_T1]
    && !(reg_wr && (reg_addr == dtc_pkg::ADDR_ICLR) && reg_wdata[dtc_pkg::EV_T1])
    |=> s_r.istat[dtc_pkg::EV_T1])
    else $error("timer 1 status bit dropped without a clear");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == dtc_pkg::RST_BYTE)
    else $error("read data not zero outside a read");

  c_reload_ovf: cover property (
    (md1 == dtc_pkg::MODE_RELOAD8) && ovf1 ##1 req_t1);
  c_split_flags: cover property (
    (md0 == dtc_pkg::MODE_SPLIT) && ovf0 ##[1:300] ovf1);
  c_irq_x1: cover property (
    !s_r.tctrl[dtc_pkg::TC_X1_TYP] && xs1 ##2 irq);
  c_t0_reload: cover property (
    (md0 == dtc_pkg::MODE_RELOAD8) && ovf0 ##1 req_t0);
  c_gate_hold: cover property (
    s_r.tmode[dtc_pkg::TM_T0_GATE] && !ext_irq0_pin_n && s_r.t0_pin_d && !t0_event_pin);

endmodule
`default_nettype wire
